// *** hw/acs_sequencer.sv ***
// Conversion sequencer with APB registers, init timing, accumulation and interrupt.
// How it works
// - Wait init: converter/amp 10us, ref 60us, temp 35us.
// - Init wait is longest enabled module time.
// - Below 2 MHz converter init is 20 cycles.
// - Low latency keeps modules powered, skips init.
// - Init still on first enable or new modules.
// - Busy flag high while initialization runs.
// - Sampling lasts sample_duration plus half cycle, amplifier_hold_sample_duration with amp.
// - Amplifier tracks, holds only during converter sampling.
// - Amplifier tracking lasts sample_duration plus one cycle.
// - Accumulate 2^sample_count_select samples, up to 1024.
// - Convert nine cycles 8-bit, thirteen otherwise.
// - Result after half cycle plus one clock, plus one more when accumulating.
// - 12-bit single: init plus sample_duration plus 15.
// - Free running restarts right after result.
// - Conversion clock divides peripheral clock by prescaler.
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer #(
  parameter int unsigned DATA_W = 12,
  parameter int unsigned ACC_W = 22
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt.
  output logic irq,
  // Analog front end.
  output acs_pkg::acs_modules_t analog_power,
  output acs_pkg::acs_analog_t analog_ctl,
  input wire logic [DATA_W-1:0] conv_data_i
);
  import acs_pkg::*;

  // Refuse widths that cannot hold 1024 summed samples.
  if (DATA_W > 16 || ACC_W < DATA_W + 10 || ACC_W > 32) begin : g_chk
    $error("acs_sequencer: unsupported DATA_W or ACC_W");
  end

  logic [8:0] ctrl_q;
  logic [3:0] clock_divider_select;
  logic [7:0] timebase_q;
  logic [7:0] sample_duration, amplifier_hold_sample_duration;
  logic [3:0] sample_count_select;
  logic [1:0] flags_q, mask_q;
  logic [ACC_W-1:0] result_q, acc_q;
  logic [DATA_W-1:0] data_q, sync1_q, sync2_q;
  acs_state_t state_q;
  logic [9:0] ph_q;
  logic [3:0] div_q;
  logic [15:0] init_cnt_q, init_target;
  logic [10:0] acc_n_q;
  logic upd_cnt_q;
  acs_modules_t cfg_req;

  // Control fields.
  logic enable, low_latency_enable, free_running_enable, mode8, use_amp;
  logic [1:0] accum_mode;
  assign enable = ctrl_q[0];
  assign low_latency_enable = ctrl_q[1];
  assign free_running_enable = ctrl_q[2];
  assign mode8 = ctrl_q[3];
  assign accum_mode = ctrl_q[5:4];
  assign use_amp = ctrl_q[6];
  assign cfg_req = '{temp_dac: ctrl_q[8], ref_int: ctrl_q[7], amp: ctrl_q[6], conv: 1'b1};

  // APB decode; the slave never waits.
  logic wr_en, rd_en, addr_ok, start_cmd;
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign addr_ok = paddr <= ACS_DATA_ADDR && paddr[1:0] == 2'b00;
  assign pslverr = psel && penable && !addr_ok;
  assign start_cmd = wr_en && paddr == ACS_CMD_ADDR && pwdata[0] && enable;

  // Read mux, zero on unmapped offsets.
  always_comb begin
    prdata = 32'h0;
    case (paddr)
      ACS_CTRL_ADDR: prdata = {23'h0, ctrl_q};
      ACS_CLOCK_ADDR: prdata = {16'h0, timebase_q, 4'h0, clock_divider_select};
      ACS_SAMPLE_ADDR: prdata = {12'h0, sample_count_select, amplifier_hold_sample_duration, sample_duration};
      ACS_STATUS_ADDR: prdata = {28'h0, state_q, state_q == ACS_INIT};
      ACS_INTFLAGS_ADDR: prdata = {30'h0, flags_q};
      ACS_INTMASK_ADDR: prdata = {30'h0, mask_q};
      ACS_RESULT_ADDR: prdata = 32'(result_q);
      ACS_DATA_ADDR: prdata = 32'(data_q);
      default: prdata = 32'h0;
    endcase
  end

  // Configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ACS_CTRL_RST;
      clock_divider_select <= 4'h0;
      timebase_q <= ACS_TIMEBASE_RST;
      sample_duration <= 8'h00;
      amplifier_hold_sample_duration <= 8'h00;
      sample_count_select <= 4'h0;
      mask_q <= 2'h0;
    end else if (wr_en) begin
      case (paddr)
        ACS_CTRL_ADDR: ctrl_q <= pwdata[8:0];
        ACS_CLOCK_ADDR: begin
          clock_divider_select <= pwdata[3:0];
          timebase_q <= pwdata[15:8];
        end
        ACS_SAMPLE_ADDR: begin
          sample_duration <= pwdata[7:0];
          amplifier_hold_sample_duration <= pwdata[15:8];
          sample_count_select <= pwdata[19:16] > ACS_MAX_SCS ? ACS_MAX_SCS : pwdata[19:16];
        end
        ACS_INTMASK_ADDR: mask_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Init length in pclk cycles: longest enabled module, all started together.
  function automatic logic [15:0] init_cycles(input acs_modules_t m, input logic [7:0] tb);
    logic [15:0] t, w;
    // Widen the timebase first, so the products never wrap at eight bits.
    w = 16'(tb);
    t = tb < ACS_SLOW_TB ? ACS_SLOW_CONV_CYC : ACS_INIT_CONV_US * w;
    if (m.amp && ACS_INIT_AMP_US * w > t) t = ACS_INIT_AMP_US * w;
    if (m.temp_dac && ACS_INIT_TEMP_US * w > t) t = ACS_INIT_TEMP_US * w;
    if (m.ref_int && ACS_INIT_REF_US * w > t) t = ACS_INIT_REF_US * w;
    return t;
  endfunction
  assign init_target = init_cycles(cfg_req, timebase_q);

  // Prescaler: one half conversion clock every clock_divider_select+1 pclk cycles.
  logic half_tick;
  assign half_tick = div_q == clock_divider_select;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_q <= 4'h0;
    // Cleared in UPDATE too, so a burst restart never begins with a short half cycle.
    else if (state_q == ACS_IDLE || state_q == ACS_INIT || state_q == ACS_UPDATE || half_tick) div_q <= 4'h0;
    else div_q <= div_q + 4'h1;
  end

  // Phase lengths in half cycles.
  logic [9:0] samp_half, track_half, conv_half, phase_len;
  logic ph_end, init_done, need_init, last_sample, powered_q;
  acs_modules_t powered_cfg_q;
  acs_state_t first_state;
  assign samp_half = use_amp ? {1'b0, amplifier_hold_sample_duration, 1'b1} : {1'b0, sample_duration, 1'b1};
  assign track_half = {1'b0, sample_duration, 1'b0} + 10'd2;
  assign conv_half = mode8 ? ACS_CONV8_HALF : ACS_CONV12_HALF;
  always_comb begin
    case (state_q)
      ACS_START: phase_len = ACS_START_HALF;
      ACS_AMP_TRACK: phase_len = track_half;
      ACS_SAMPLE: phase_len = samp_half;
      ACS_CONVERT: phase_len = conv_half;
      default: phase_len = ACS_SETTLE_HALF;
    endcase
  end
  assign ph_end = half_tick && ph_q == phase_len - 10'd1;
  assign init_done = init_cnt_q >= init_target - 16'd1;
  assign need_init = !(low_latency_enable && powered_q && (cfg_req & ~powered_cfg_q) == '0);
  assign first_state = use_amp ? ACS_AMP_TRACK : ACS_START;
  assign last_sample = accum_mode == ACS_ACC_SINGLE || acc_n_q == (11'd1 << sample_count_select) - 11'd1;

  // Main sequencer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ACS_IDLE;
      upd_cnt_q <= 1'b0;
    end else if (!enable) begin
      state_q <= ACS_IDLE;
    end else begin
      case (state_q)
        ACS_IDLE: if (start_cmd) state_q <= need_init ? ACS_INIT : first_state;
        ACS_INIT: if (init_done) state_q <= first_state;
        ACS_START: if (ph_end) state_q <= ACS_SAMPLE;
        ACS_AMP_TRACK: if (ph_end) state_q <= ACS_SAMPLE;
        ACS_SAMPLE: if (ph_end) state_q <= ACS_CONVERT;
        ACS_CONVERT: if (ph_end) state_q <= ACS_SETTLE;
        ACS_SETTLE: if (ph_end) begin
          state_q <= ACS_UPDATE;
          upd_cnt_q <= 1'b0;
        end
        ACS_UPDATE: begin
          // The final accumulated result takes one extra clock.
          upd_cnt_q <= 1'b1;
          if (!last_sample) begin
            // A series waits in idle for the next start command; a burst goes straight on.
            state_q <= accum_mode == ACS_ACC_SERIES ? ACS_IDLE : first_state;
          end else if (accum_mode == ACS_ACC_SINGLE || upd_cnt_q) begin
            state_q <= !free_running_enable ? ACS_IDLE : need_init ? ACS_INIT : first_state;
          end
        end
        default: state_q <= ACS_IDLE;
      endcase
    end
  end

  // Phase and init counters restart on every state change.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 10'h0;
      init_cnt_q <= 16'h0;
    end else begin
      ph_q <= (ph_end || state_q == ACS_IDLE || state_q == ACS_INIT) ? 10'h0 : ph_q + 10'(half_tick);
      init_cnt_q <= state_q == ACS_INIT ? init_cnt_q + 16'd1 : 16'h0;
    end
  end

  // Power bookkeeping: modules stay on after the last result only in low latency or free running.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powered_q <= 1'b0;
      powered_cfg_q <= '0;
    end else if (!enable) begin
      powered_q <= 1'b0;
      powered_cfg_q <= '0;
    end else if (state_q == ACS_INIT) begin
      powered_q <= 1'b1;
      powered_cfg_q <= cfg_req;
    end else if (state_q == ACS_UPDATE && last_sample && !low_latency_enable && !free_running_enable
                 && (accum_mode == ACS_ACC_SINGLE || upd_cnt_q)) begin
      powered_q <= 1'b0;
      powered_cfg_q <= '0;
    end
  end
  assign analog_power = powered_cfg_q;

  // Analog strobes decoded from the state.
  assign analog_ctl = '{
    amp_track: use_amp && powered_q && state_q != ACS_SAMPLE && state_q != ACS_INIT,
    amp_hold: use_amp && state_q == ACS_SAMPLE,
    adc_sample: state_q == ACS_SAMPLE,
    adc_convert: state_q == ACS_CONVERT
  };

  // Converter data arrives from the analog side, so it is synchronised.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= conv_data_i;
      sync2_q <= sync1_q;
    end
  end

  // Sample capture, accumulation and result update.
  logic sample_evt, result_evt;
  assign sample_evt = state_q == ACS_UPDATE && !upd_cnt_q;
  assign result_evt = sample_evt && last_sample && accum_mode == ACS_ACC_SINGLE
                      || state_q == ACS_UPDATE && upd_cnt_q && last_sample;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= '0;
      acc_q <= '0;
      acc_n_q <= 11'h0;
      result_q <= '0;
    end else begin
      if (sample_evt) begin
        data_q <= sync2_q;
        acc_q <= acc_n_q == 11'h0 ? ACC_W'(sync2_q) : acc_q + ACC_W'(sync2_q);
        // The index stays on the last sample until the result is taken, one clock later when accumulating.
        acc_n_q <= last_sample ? acc_n_q : acc_n_q + 11'd1;
      end
      if (result_evt) result_q <= accum_mode == ACS_ACC_SINGLE ? ACC_W'(sync2_q) : acc_q;
      if (result_evt || !enable) acc_n_q <= 11'h0;
    end
  end

  // Sticky flags: reading clears them, but a new event in that cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flags_q <= 2'h0;
    else flags_q <= (rd_en && paddr == ACS_INTFLAGS_ADDR ? 2'h0 : flags_q) | {sample_evt, result_evt};
  end
  assign irq = |(flags_q & mask_q);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  busy_init_a: assert property (prdata[0] == (state_q == ACS_INIT) || paddr != ACS_STATUS_ADDR)
    else $error("busy flag differs from init state");
  init_hold_a: assert property (state_q == ACS_INIT && !init_done && enable |=> state_q == ACS_INIT)
    else $error("init left early");
  init_ref_a: assert property (cfg_req.ref_int && timebase_q >= ACS_SLOW_TB
    |-> init_target == ACS_INIT_REF_US * 16'(timebase_q))
    else $error("init length not the longest");
  slow_clk_a: assert property (timebase_q < ACS_SLOW_TB && !cfg_req.amp && !cfg_req.ref_int && !cfg_req.temp_dac
    |-> init_target == ACS_SLOW_CONV_CYC)
    else $error("slow clock init wrong");
  low_latency_enable_skip_a: assert property (state_q == ACS_IDLE && start_cmd && !need_init |=> state_q != ACS_INIT)
    else $error("init despite low latency");
  sample_len_a: assert property (state_q == ACS_CONVERT && $past(state_q) == ACS_SAMPLE
    |-> $past(ph_q) == samp_half - 10'd1)
    else $error("sample period wrong");
  conv_len_a: assert property (state_q == ACS_SETTLE && $past(state_q) == ACS_CONVERT
    |-> $past(ph_q) == conv_half - 10'd1)
    else $error("conversion length wrong");
  settle_upd_a: assert property (state_q == ACS_SETTLE && ph_end && enable
    |=> state_q == ACS_UPDATE ##1 data_q == $past(sync2_q))
    else $error("result not updated");
  amp_hold_a: assert property (analog_ctl.amp_hold |-> analog_ctl.adc_sample && !analog_ctl.amp_track)
    else $error("amplifier hold outside sampling");
  free_running_enable_a: assert property (result_evt && free_running_enable && enable |=> state_q != ACS_IDLE)
    else $error("free running did not restart");
  first_init_a: assert property (state_q == ACS_IDLE && start_cmd && !powered_q |=> state_q == ACS_INIT)
    else $error("first enable skipped init");
  cov_single_c: cover property (state_q == ACS_CONVERT ##[1:300] result_evt);
  cov_burst_c: cover property (accum_mode == ACS_ACC_BURST && result_evt);
  cov_free_running_enable_c: cover property (result_evt && free_running_enable);
endmodule
`default_nettype wire

// *** hw/acs_pkg.sv ***
// Constants, types and register map of the conversion sequencer.
package acs_pkg;
  // Register byte offsets on the APB.
  localparam logic [7:0] ACS_CTRL_ADDR = 8'h00;
  localparam logic [7:0] ACS_CLOCK_ADDR = 8'h04;
  localparam logic [7:0] ACS_SAMPLE_ADDR = 8'h08;
  localparam logic [7:0] ACS_CMD_ADDR = 8'h0c;
  localparam logic [7:0] ACS_STATUS_ADDR = 8'h10;
  localparam logic [7:0] ACS_INTFLAGS_ADDR = 8'h14;
  localparam logic [7:0] ACS_INTMASK_ADDR = 8'h18;
  localparam logic [7:0] ACS_RESULT_ADDR = 8'h1c;
  localparam logic [7:0] ACS_DATA_ADDR = 8'h20;
  // Reset values.
  localparam int unsigned ACS_PCLK_MHZ = 250;
  localparam logic [7:0] ACS_TIMEBASE_RST = 8'(ACS_PCLK_MHZ);
  localparam logic [8:0] ACS_CTRL_RST = 9'h000;
  // Module initialization times in microseconds.
  localparam logic [7:0] ACS_INIT_CONV_US = 8'd10;
  localparam logic [7:0] ACS_INIT_AMP_US = 8'd10;
  localparam logic [7:0] ACS_INIT_REF_US = 8'd60;
  localparam logic [7:0] ACS_INIT_TEMP_US = 8'd35;
  // Slow peripheral clock: fixed converter init in clock cycles.
  localparam logic [7:0] ACS_SLOW_TB = 8'd2;
  localparam logic [15:0] ACS_SLOW_CONV_CYC = 16'd20;
  // Phase lengths in half conversion clock cycles, and the largest sample_count_select.
  localparam logic [9:0] ACS_START_HALF = 10'd2;
  localparam logic [9:0] ACS_CONV8_HALF = 10'd18;
  localparam logic [9:0] ACS_CONV12_HALF = 10'd26;
  localparam logic [9:0] ACS_SETTLE_HALF = 10'd1;
  localparam logic [3:0] ACS_MAX_SCS = 4'd10;
  // Accumulation modes.
  localparam logic [1:0] ACS_ACC_SINGLE = 2'd0;
  localparam logic [1:0] ACS_ACC_SERIES = 2'd1;
  localparam logic [1:0] ACS_ACC_BURST = 2'd2;
  // Interrupt flag positions.
  localparam int unsigned ACS_IRQ_RESULT = 0;
  localparam int unsigned ACS_IRQ_SAMPLE = 1;

  typedef enum logic [2:0] {
    ACS_IDLE = 3'b000, ACS_INIT = 3'b001, ACS_START = 3'b010, ACS_AMP_TRACK = 3'b011,
    ACS_SAMPLE = 3'b100, ACS_CONVERT = 3'b101, ACS_SETTLE = 3'b110, ACS_UPDATE = 3'b111
  } acs_state_t;

  // Analog modules that may need powering and initialization.
  typedef struct packed {
    logic temp_dac;
    logic ref_int;
    logic amp;
    logic conv;
  } acs_modules_t;

  // Strobes toward the analog front end.
  typedef struct packed {
    logic amp_track;
    logic amp_hold;
    logic adc_sample;
    logic adc_convert;
  } acs_analog_t;
endpackage

// *** testbench/acs_afe_model.sv ***
// Behavioural analog front end that answers the sequencer's conversion strobes.
`timescale 1ns/100ps
`default_nettype none
module acs_afe_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Strobes from the sequencer.
  input wire acs_pkg::acs_analog_t analog_ctl,
  // Result toward the sequencer and the count of conversions begun.
  output logic [11:0] conv_data_i,
  output var int n_conv
);
  import acs_pkg::*;
  logic conv_q;
  int hold_q;
  // Each conversion launches a fresh code, held long enough to cross the design's input flops.
  // Afterwards the line toggles every cycle, so a late capture never matches by luck.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_q <= 1'b0;
      hold_q <= 0;
      n_conv <= 0;
      conv_data_i <= 12'h000;
    end else begin
      conv_q <= analog_ctl.adc_convert;
      if (analog_ctl.adc_convert && !conv_q) begin
        conv_data_i <= 12'(32'h0a5 + n_conv * 32'h0b3);
        n_conv <= n_conv + 1;
        hold_q <= 12;
      end else if (!analog_ctl.adc_convert) begin
        if (hold_q > 0) hold_q <= hold_q - 1;
        else conv_data_i <= ~conv_data_i;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/adc_conversion_sequencer_tb.sv ***
// Self-checking bench for the conversion sequencer with its analog front-end model.
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_sequencer_tb;
  import acs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, slv, rdy, bsy;
  acs_modules_t analog_power;
  acs_analog_t analog_ctl;
  logic [11:0] conv_data;
  int n_conv, err_count, n_checks, cyc, t0, act_at, fall_at, irq_at, k, h, wat;
  int cnt[4];
  int wid[4];
  integer seed = 32'h66b79ba4;
  always #2 pclk = ~pclk;
  acs_sequencer dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .analog_power(analog_power), .analog_ctl(analog_ctl), .conv_data_i(conv_data));
  acs_afe_model afe_u (.pclk(pclk), .presetn(presetn), .analog_ctl(analog_ctl), .conv_data_i(conv_data),
    .n_conv(n_conv));
  // Widths and event times are taken on the falling edge, where every flop output has settled.
  always @(negedge pclk) begin
    cyc++;
    if (analog_ctl != 4'h0 && act_at < t0) act_at = cyc;
    if (irq === 1'b1 && irq_at < t0) begin
      irq_at = cyc;
      k = n_conv;
    end
    for (int i = 0; i < 4; i++) begin
      if (analog_ctl[i]) cnt[i]++;
      else if (cnt[i] != 0) begin
        // The amplifier tracks again after sampling, so only its first pulse of a run counts.
        if (i != 3 || wat < t0) wid[i] = cnt[i];
        if (i == 3) wat = cyc;
        cnt[i] = 0;
        if (i == 0) fall_at = cyc;
      end
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; read data is taken at the edge that samples pready, before any flop moves.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      rd = prdata;
      slv = pslverr;
      rdy = pready;
      t++;
    end while (rdy !== 1'b1 && t < 64);
    if (t == 64) err_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] code(input int n);
    return 32'(12'(32'h0a5 + n * 32'h0b3));
  endfunction
  // Runs one conversion (go=0 waits for a free-running one), then checks timing, result and flags.
  task automatic conv(input logic [31:0] ctrl, input logic [31:0] smp, input logic [31:0] msk,
      input logic [31:0] flg, input int n, input bit go, output int d);
    int t;
    logic [31:0] sum;
    if (go) begin
      apb(1, ACS_CTRL_ADDR, ctrl);
      apb(1, ACS_SAMPLE_ADDR, smp);
      apb(1, ACS_INTMASK_ADDR, msk);
      apb(1, ACS_CMD_ADDR, 32'h1);
    end
    t0 = cyc;
    if (go) apb(0, ACS_STATUS_ADDR, 32'h0);
    bsy = rd[0];
    t = 0;
    while (irq !== 1'b1 && t < 40000) begin
      @(negedge pclk);
      t++;
    end
    if (t == 40000) err_count++;
    // Let the falling-edge monitor finish its bookkeeping before the widths are read.
    @(posedge pclk);
    d = act_at - t0;
    check(wid[0], (ctrl[3] ? 18 : 26) * h);
    check(wid[1], (ctrl[6] ? 2 * smp[15:8] + 1 : 2 * smp[7:0] + 1) * h);
    if (ctrl[6]) check(wid[3], (2 * smp[7:0] + 2) * h);
    if (ctrl[6]) check(wid[2], wid[1]);
    if (msk == 1) check(irq_at - fall_at, h + (ctrl[5:4] != 0 ? 2 : 1));
    sum = 32'h0;
    for (int j = k - n; j < k; j++) sum += code(j);
    if (n > 0) apb(0, ACS_RESULT_ADDR, 32'h0);
    if (n > 0) check(rd, sum);
    apb(1, ACS_INTMASK_ADDR, 32'h0);
    @(negedge pclk) check({31'h0, irq}, 32'h0);
    apb(1, ACS_INTMASK_ADDR, msk);
    @(negedge pclk) check({31'h0, irq}, 32'h1);
    apb(0, ACS_INTFLAGS_ADDR, 32'h0);
    check(rd, flg);
    @(negedge pclk) check({31'h0, irq}, 32'h0);
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // The longest test is the 1024-sample burst, near 32k cycles; allow well beyond that.
  initial begin
    #360000;
    err_count++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    conclude();
  end
  initial begin
    int d0, d1, d2, sd, ah, dv, m, a;
    h = 1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ACS_CLOCK_ADDR, 32'h0);
    check(rd, {16'h0, ACS_TIMEBASE_RST, 8'h00});
    apb(0, 8'h24, 32'h0);
    check({rd[30:0], slv}, 32'h1);
    $display("Test reset and access done");
    // Differences between configurations cancel the fixed start overhead.
    apb(1, ACS_CLOCK_ADDR, 32'h0400);
    conv(32'h001, 32'h2, 32'h1, 32'h3, 1, 1, d0);
    check({31'h0, bsy}, 32'h1);
    conv(32'h081, 32'h2, 32'h1, 32'h3, 1, 1, d1);
    check(d1 - d0, 200);
    conv(32'h181, 32'h2, 32'h1, 32'h3, 1, 1, d1);
    check(d1 - d0, 200);
    conv(32'h101, 32'h2, 32'h1, 32'h3, 1, 1, d1);
    check(d1 - d0, 100);
    apb(1, ACS_CLOCK_ADDR, 32'h0100);
    conv(32'h001, 32'h2, 32'h1, 32'h3, 1, 1, d1);
    check(d1 - d0, -20);
    $display("Test init timing done");
    conv(32'h003, 32'h2, 32'h1, 32'h3, 1, 1, d0);
    conv(32'h003, 32'h2, 32'h1, 32'h3, 1, 1, d1);
    check(d0 - d1, 20);
    check({31'h0, bsy}, 32'h0);
    conv(32'h083, 32'h2, 32'h1, 32'h3, 1, 1, d2);
    check(d2 - d1, 60);
    apb(1, ACS_CTRL_ADDR, 32'h0);
    // Power drops one clock after enable falls.
    repeat (2) @(negedge pclk);
    check({28'h0, analog_power}, 32'h0);
    $display("Test low latency done");
    for (int i = 0; i < 6; i++) begin
      sd = $random(seed) & 7;
      ah = $random(seed) & 7;
      dv = $random(seed) & 1;
      m = $random(seed) & 1;
      a = $random(seed) & 1;
      h = dv + 1;
      apb(1, ACS_CLOCK_ADDR, 32'h0100 | dv);
      conv(32'h1 | m << 3 | a << 6, ah << 8 | sd, 32'h1, 32'h3, m ? 0 : 1, 1, d0);
    end
    h = 1;
    apb(1, ACS_CLOCK_ADDR, 32'h0100);
    $display("Test random phases done");
    conv(32'h011, 32'h1_0002, 32'h2, 32'h2, 0, 1, d0);
    conv(32'h011, 32'h1_0002, 32'h1, 32'h3, 2, 1, d0);
    // Bursts run without the amplifier, so no sample_duration floor is owed.
    conv(32'h021, 32'h2_0002, 32'h1, 32'h3, 4, 1, d0);
    conv(32'h021, 32'hf_0000, 32'h1, 32'h3, 1024, 1, d0);
    apb(0, ACS_DATA_ADDR, 32'h0);
    check(rd, code(k - 1));
    $display("Test accumulation done");
    conv(32'h005, 32'h2, 32'h1, 32'h3, 1, 1, d0);
    conv(32'h005, 32'h2, 32'h1, 32'h3, 1, 0, d0);
    apb(1, ACS_CTRL_ADDR, 32'h0);
    repeat (4) @(negedge pclk);
    check({28'h0, analog_ctl}, 32'h0);
    $display("Test free running done");
    conclude();
  end
endmodule
`default_nettype wire
